/* File: tb/gate_ctrl_chk.sv */
`timescale 1ns/1ps
module gate_ctrl_chk
  #(parameter int MUTE_CYC   = 4,
    parameter int FILTER_CYC = 4)
  (
  input wire logic                     mclk_i,
  input wire logic                     rst_n_i,
  input wire logic                     pwm_opp_i,
  input wire gate_ctrl_pkg::pwm_mode_t mode_i,
  input wire logic                     auto_reset_i,
  input wire logic                     in_pos_o,
  input wire logic                     in_neg_o,
  input wire logic                     rst_en_o,
  input wire logic                     clear_busy_o
);
  import gate_ctrl_pkg::*;
  // ------------------------------------------------------------
  // Pin timing checks.
  // ------------------------------------------------------------
  logic [7:0] low_r;
  always_ff @(posedge mclk_i)
    low_r <= !rst_n_i ? 8'hff : in_pos_o ? 8'h00 : low_r + {7'h00, low_r != 8'hff};
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  neg_tied_a:
    assert property ((mode_i == MODE_NONINV) [*2] |-> !in_neg_o) else $error("neg set");
  opp_follow_a:
    assert property ((mode_i == MODE_INTERLOCK && $stable(pwm_opp_i)) [*3]
      |-> in_neg_o == pwm_opp_i) else $error("neg not opp");
  mute_wait_a:
    assert property ($fell(rst_en_o) && clear_busy_o |-> $past(clear_busy_o, MUTE_CYC))
      else $error("reset in mute");
  hold_low_a:
    assert property ($fell(rst_en_o) && clear_busy_o |=> !rst_en_o [*4])
      else $error("reset too short");
  auto_follow_a:
    assert property ((auto_reset_i && mode_i == MODE_NONINV) [*2] |-> rst_en_o == in_pos_o)
      else $error("enable not pwm");
  off_time_a:
    assert property ($rose(in_pos_o) && auto_reset_i |-> low_r > FILTER_CYC)
      else $error("off time short");
  min_level_a:
    assert property ($changed(in_pos_o) |=> $stable(in_pos_o) [*2]) else $error("glitch");
endmodule

/* File: tb/gate_ctrl_tb_top.sv */
`timescale 1ns/1ps
bind gate_ctrl gate_ctrl_chk #(.MUTE_CYC(MUTE_CYC), .FILTER_CYC(FILTER_CYC)) u_chk (.mclk_i,
  .rst_n_i, .pwm_opp_i, .mode_i, .auto_reset_i, .in_pos_o, .in_neg_o, .rst_en_o, .clear_busy_o);
module gate_ctrl_tb_top;
  import gate_ctrl_pkg::*;
  logic      mclk_i  = 1'b0;
  logic      rst_n_i = 1'b0;
  logic      own, opp, en, aut, clr, oc, uv;
  pwm_mode_t mode;
  logic      pos, neg, rsten, fault_flag_n, rdy, busy;
  wire       gate;
  tri1       flt_w, pg_w;
  int        bad_count = 0;
  int        cmp_count = 0;
  int        cyc_count = 0;
  gate_ctrl #(.MUTE_CYC(4), .FILTER_CYC(4)) u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .pwm_own_i(own), .pwm_opp_i(opp), .mode_i(mode), .enable_i(en), .auto_reset_i(aut),
    .fault_clear_i(clr), .fault_flag_n_i(flt_w), .power_good_i(pg_w), .in_pos_o(pos),
    .in_neg_o(neg), .rst_en_o(rsten), .fault_o(fault_flag_n), .ready_o(rdy), .clear_busy_o(busy));
  gate_drv_model u_drv (.mclk_i(mclk_i), .pos_i(pos), .neg_i(neg), .en_i(rsten), .oc_i(oc),
    .uv_i(uv), .fault_flag_n_o(flt_w), .power_good_o(pg_w), .gate_o(gate));
  // ------------------------------------------------------------
  // Helpers and scenarios.
  // ------------------------------------------------------------
  initial
    forever #10 mclk_i = ~mclk_i;
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk_i)
  begin
    cyc_count++;
    if (cyc_count == 3000)
    begin
      bad_count++;
      test_done();
    end
  end
  task automatic t_noninv();
    own = 1'b1;
    cyc(4);
    chk(neg, 1'b0);
    chk(gate, 1'b1);
    own = 1'b0;
    cyc(4);
    chk(gate, 1'b0);
  endtask
  task automatic t_lock();
    mode = MODE_INTERLOCK;
    {own, opp} = 2'h3;
    cyc(5);
    chk(neg, 1'b1);
    chk(gate, 1'b0);
    opp = 1'b0;
    cyc(5);
    chk(gate, 1'b1);
    own = 1'b0;
    cyc(5);
  endtask
  task automatic t_inv();
    mode = MODE_INVERTING;
    aut = 1'b1;
    own = 1'b1;
    cyc(5);
    chk(pos, 1'b1);
    chk(gate, 1'b1);
    chk(rsten, 1'b1);
    own = 1'b0;
    cyc(5);
    chk(neg, 1'b1);
    chk(rsten, 1'b0);
    mode = MODE_NONINV;
    aut = 1'b0;
    cyc(5);
  endtask
  task automatic t_fault();
    own = 1'b1;
    cyc(4);
    oc = 1'b1;
    cyc(1);
    oc = 1'b0;
    cyc(6);
    chk(fault_flag_n, 1'b1);
    chk(gate, 1'b0);
    chk(busy, 1'b1);
    chk(rsten, 1'b1);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    for (int i = 0; i < 80 && busy !== 1'b0; i++)
      cyc(1);
    chk(busy, 1'b0);
    chk(fault_flag_n, 1'b0);
    chk(rsten, 1'b1);
    chk(gate, 1'b1);
    own = 1'b0;
    cyc(6);
  endtask
  task automatic t_auto();
    aut = 1'b1;
    cyc(8);
    own = 1'b1;
    cyc(5);
    oc = 1'b1;
    cyc(1);
    oc = 1'b0;
    cyc(6);
    own = 1'b0;
    cyc(3);
    own = 1'b1;
    cyc(14);
    chk(fault_flag_n, 1'b0);
    chk(gate, 1'b1);
    {own, aut} = 2'h0;
    cyc(8);
  endtask
  task automatic t_dis();
    {en, own} = 2'h1;
    cyc(5);
    chk(rsten, 1'b0);
    chk(gate, 1'b0);
    {en, own} = 2'h2;
    cyc(5);
  endtask
  task automatic t_uv();
    {uv, own} = 2'h3;
    cyc(5);
    chk(rdy, 1'b0);
    chk(gate, 1'b0);
    uv = 1'b0;
    cyc(5);
    chk(rdy, 1'b1);
    chk(gate, 1'b1);
    own = 1'b0;
  endtask
  initial
  begin
    {own, opp, en, aut, clr, oc, uv} = 7'h00;
    mode = MODE_NONINV;
    repeat (5) @(negedge mclk_i);
    chk(rsten, 1'b0);
    rst_n_i = 1'b1;
    en = 1'b1;
    cyc(4);
    t_noninv();
    t_lock();
    t_inv();
    t_fault();
    t_auto();
    t_dis();
    t_uv();
    test_done();
  end
endmodule

/* File: tb/gate_drv_model.sv */
`timescale 1ns/1ps
module gate_drv_model
  #(parameter int MUTE = 4,
    parameter int FILT = 4)
  (
  input  wire logic mclk_i,
  input  wire logic pos_i,
  input  wire logic neg_i,
  input  wire logic en_i,
  input  wire logic oc_i,
  input  wire logic uv_i,
  output wire       fault_flag_n_o,
  output wire       power_good_o,
  output wire       gate_o
);
  // ------------------------------------------------------------
  // Driver behaviour.
  // ------------------------------------------------------------
  logic [2:0] s_r   = 3'h0;
  logic [2:0] f_r   = 3'h0;
  logic       lat_r = 1'b0;
  int         cnt_r = 0;
  int         low_r = 0;
  wire  [2:0] in_w  = {pos_i, neg_i, en_i === 1'b1};
  wire  [2:0] eq_w  = ~(s_r ^ in_w);
  always @(posedge mclk_i)
  begin
    s_r <= in_w;
    f_r <= (f_r & ~eq_w) | (in_w & eq_w);
    if (oc_i && gate_o)
    begin
      lat_r <= 1'b1;
      cnt_r <= 0;
      low_r <= 0;
    end
    else if (lat_r)
    begin
      cnt_r <= cnt_r + 1;
      low_r <= (cnt_r >= MUTE && !f_r[0]) ? low_r + 1 : 0;
      if (low_r >= FILT)
        lat_r <= 1'b0;
    end
  end
  assign gate_o = f_r[2] && !f_r[1] && f_r[0] && !lat_r && !uv_i;
  assign fault_flag_n_o = lat_r ? 1'b0 : 1'bz;
  assign power_good_o = uv_i ? 1'b0 : 1'bz;
endmodule

/* File: verilog/gate_ctrl.sv */
`timescale 1ns/1ps
`include "gate_ctrl_params.svh"

// Operation
// - To clear a fault the controller pulls enable/reset low after the mute time and holds it for at least the reset filter time.
// - The controller always drives both PWM inputs and enable/reset, tying the inverting input low when it is unused.
// - In interlock mode the controller puts its own PWM on the noninverting input and the opposite switch's PWM on the inverting input.
// - In automatic reset the enable/reset pin follows the noninverting PWM, or the inverse of the PWM on the inverting input.
// - In automatic reset every PWM off-time is stretched beyond the reset filter time.
module gate_ctrl
  #(parameter int CNT_W       = 16,
    parameter int MUTE_CYC    = `GC_MUTE_CYC,
    parameter int FILTER_CYC  = `GC_FILTER_CYC,
    parameter int MIN_LVL_CYC = `GC_DEGLITCH_CYC)
  (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    pwm_own_i,
  input  wire logic                    pwm_opp_i,
  input  wire gate_ctrl_pkg::pwm_mode_t mode_i,
  input  wire logic                    enable_i,
  input  wire logic                    auto_reset_i,
  input  wire logic                    fault_clear_i,
  input  wire logic                    fault_flag_n_i,
  input  wire logic                    power_good_i,
  output logic                         in_pos_o,
  output logic                         in_neg_o,
  output logic                         rst_en_o,
  output logic                         fault_o,
  output logic                         ready_o,
  output logic                         clear_busy_o
);
  import gate_ctrl_pkg::*;

  pin_status_if status ();

  pin_sync u_pin_sync (
    .mclk_i         (mclk_i),
    .rst_n_i        (rst_n_i),
    .fault_flag_n_i (fault_flag_n_i),
    .power_good_i   (power_good_i),
    .status         (status.src)
  );

  clear_state_t     state_r;
  clear_state_t     state_nxt;
  logic [CNT_W-1:0] wait_r;
  logic [CNT_W-1:0] wait_nxt;
  logic             clr_req_r;
  logic             clr_req_nxt;
  logic [CNT_W-1:0] off_r;
  logic [CNT_W-1:0] off_nxt;
  logic [CNT_W-1:0] lvl_r;
  logic [CNT_W-1:0] lvl_nxt;
  logic             gate_r;
  logic             gate_nxt;
  logic             pos_nxt;
  logic             neg_nxt;
  logic             rst_en_nxt;
  logic             fault_nxt;
  logic             ready_nxt;
  logic             busy_nxt;
  logic [CNT_W-1:0] off_min;

  assign off_min = CNT_W'(FILTER_CYC + 1);

  // --------------------------------------------------------------------------
  // Fault clear sequence.
  // --------------------------------------------------------------------------
  always_comb
  begin
    state_nxt   = state_r;
    wait_nxt    = wait_r;
    clr_req_nxt = clr_req_r | fault_clear_i;
    unique case (state_r)
      ST_RUN:
      begin
        clr_req_nxt = 1'b0;
        if (!status.fault_n && !auto_reset_i)
        begin
          state_nxt = ST_MUTE;
          wait_nxt  = `GC_CNT_ZERO;
        end
      end
      ST_MUTE:
      begin
        if (wait_r < CNT_W'(MUTE_CYC))
          wait_nxt = wait_r + `GC_CNT_ONE;
        else if (clr_req_r)
        begin
          state_nxt   = ST_RESET;
          wait_nxt    = `GC_CNT_ZERO;
          clr_req_nxt = 1'b0;
        end
      end
      ST_RESET:
      begin
        if (wait_r < CNT_W'(FILTER_CYC))
          wait_nxt = wait_r + `GC_CNT_ONE;
        else
        begin
          state_nxt = ST_RECOVER;
          wait_nxt  = `GC_CNT_ZERO;
        end
      end
      ST_RECOVER:
      begin
        if (status.fault_n)
          state_nxt = ST_RUN;
        else if (wait_r < CNT_W'(`GC_RECOVER_CYC))
          wait_nxt = wait_r + `GC_CNT_ONE;
        else
        begin
          state_nxt = ST_MUTE;
          wait_nxt  = `GC_CNT_ZERO;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      state_r   <= ST_RUN;
      wait_r    <= `GC_CNT_ZERO;
      clr_req_r <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      wait_r    <= wait_nxt;
      clr_req_r <= clr_req_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // PWM shaping and pin drive.
  // --------------------------------------------------------------------------
  always_comb
  begin
    gate_nxt = gate_r;
    off_nxt  = off_r;
    lvl_nxt  = lvl_r;
    if (lvl_r < CNT_W'(MIN_LVL_CYC))
      lvl_nxt = lvl_r + `GC_CNT_ONE;
    else if (gate_r && !pwm_own_i)
    begin
      gate_nxt = 1'b0;
      lvl_nxt  = `GC_CNT_ZERO;
      off_nxt  = `GC_CNT_ZERO;
    end
    else if (!gate_r && pwm_own_i && (!auto_reset_i || off_r >= off_min))
    begin
      gate_nxt = 1'b1;
      lvl_nxt  = `GC_CNT_ZERO;
    end
    if (!gate_r && off_r < off_min)
      off_nxt = off_r + `GC_CNT_ONE;

    unique case (mode_i)
      MODE_INTERLOCK:
      begin
        pos_nxt = gate_nxt;
        neg_nxt = pwm_opp_i;
      end
      MODE_INVERTING:
      begin
        pos_nxt = 1'b1;
        neg_nxt = ~gate_nxt;
      end
      default:
      begin
        pos_nxt = gate_nxt;
        neg_nxt = 1'b0;
      end
    endcase

    if (auto_reset_i)
      rst_en_nxt = (mode_i == MODE_INVERTING) ? ~neg_nxt : pos_nxt;
    else
      rst_en_nxt = enable_i && (state_nxt != ST_RESET);

    fault_nxt = ~status.fault_n;
    ready_nxt = status.power_good;
    busy_nxt  = (state_nxt != ST_RUN);
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      gate_r       <= `GC_PIN_RST;
      off_r        <= `GC_CNT_ZERO;
      lvl_r        <= `GC_CNT_ZERO;
      in_pos_o     <= `GC_PIN_RST;
      in_neg_o     <= `GC_PIN_RST;
      rst_en_o     <= `GC_PIN_RST;
      fault_o      <= `GC_PIN_RST;
      ready_o      <= `GC_PIN_RST;
      clear_busy_o <= `GC_PIN_RST;
    end
    else
    begin
      gate_r       <= gate_nxt;
      off_r        <= off_nxt;
      lvl_r        <= lvl_nxt;
      in_pos_o     <= pos_nxt;
      in_neg_o     <= neg_nxt;
      rst_en_o     <= rst_en_nxt;
      fault_o      <= fault_nxt;
      ready_o      <= ready_nxt;
      clear_busy_o <= busy_nxt;
    end
  end

endmodule

/* File: verilog/gate_ctrl_params.svh */
`ifndef GATE_CTRL_PARAMS_SVH
`define GATE_CTRL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing in nanoseconds, derived cycle counts and a fixed recover cycle count.
// ----------------------------------------------------------------------------
`define GC_CLK_PERIOD_NS          20
`define GC_DEGLITCH_TIME_NS       40
`define GC_FAULT_MUTE_TIME_NS     2000
`define GC_RESET_FILTER_TIME_NS   1000
`define GC_DEGLITCH_CYC   ((`GC_DEGLITCH_TIME_NS + `GC_CLK_PERIOD_NS - 1) / `GC_CLK_PERIOD_NS)
`define GC_MUTE_CYC       ((`GC_FAULT_MUTE_TIME_NS + `GC_CLK_PERIOD_NS - 1) / `GC_CLK_PERIOD_NS)
`define GC_FILTER_CYC     ((`GC_RESET_FILTER_TIME_NS + `GC_CLK_PERIOD_NS - 1) / `GC_CLK_PERIOD_NS)
`define GC_RECOVER_CYC    16

// ----------------------------------------------------------------------------
// Reset values of pin drives and status, and counter zero and one constants.
// ----------------------------------------------------------------------------
`define GC_PIN_RST        1'b0
`define GC_SYNC_RST       2'h1
`define GC_CNT_ZERO       16'h0000
`define GC_CNT_ONE        16'h0001

`endif

/* File: verilog/gate_ctrl_pkg.sv */
package gate_ctrl_pkg;

  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_MUTE    = 2'b01,
    ST_RESET   = 2'b10,
    ST_RECOVER = 2'b11
  } clear_state_t;

  typedef enum logic [1:0] {
    MODE_NONINV    = 2'b00,
    MODE_INTERLOCK = 2'b01,
    MODE_INVERTING = 2'b10
  } pwm_mode_t;

endpackage

/* File: verilog/pin_status_if.sv */
`timescale 1ns/1ps

interface pin_status_if;
  logic fault_n;
  logic power_good;

  modport src (output fault_n, output power_good);
  modport dst (input fault_n, input power_good);
endinterface

/* File: verilog/pin_sync.sv */
`timescale 1ns/1ps
`include "gate_ctrl_params.svh"

module pin_sync (
  input  wire logic   mclk_i,
  input  wire logic   rst_n_i,
  input  wire logic   fault_flag_n_i,
  input  wire logic   power_good_i,
  pin_status_if.src   status
);

  logic [1:0] meta_r;
  logic [1:0] meta_nxt;
  logic [1:0] sync_r;
  logic [1:0] sync_nxt;

  // --------------------------------------------------------------------------
  // Two flip-flop synchroniser for the open-drain indications.
  // --------------------------------------------------------------------------
  always_comb
  begin
    meta_nxt = {power_good_i, fault_flag_n_i};
    sync_nxt = meta_r;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= `GC_SYNC_RST;
      sync_r <= `GC_SYNC_RST;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign status.fault_n    = sync_r[0];
  assign status.power_good = sync_r[1];

endmodule
